// File: hcc_top.sv
// Calibration counters for the fine capture unit, with register port.
// Assumes a single 40 MHz ref_clk; the fine clock arrives as a pin and is
// counted by its synchronised rising edges.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_defines.svh"

module hcc_top
   import hcc_pkg::*;
(
   input wire logic ref_clk, // System clock, 40 MHz
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic fine_clock, // Fine clock pin
   input wire logic [`HCC_ADDR_W-1:0] addr, // Register byte address
   input wire logic [`HCC_DATA_W-1:0] wr_data, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output logic [`HCC_DATA_W-1:0] rd_data, // Read data, cycle after strobe
   output logic irq // Calibration interrupt level
);

   hcc_core_t s_q;
   hcc_core_t s_d;
   logic fine_rise;
   logic match;
   logic overrun;
   logic wr_int_enable;
   logic wr_int_clear;
   logic [`HCC_IRQ_W-1:0] int_set;
   logic [`HCC_IRQ_W-1:0] int_status;
   logic [`HCC_IRQ_W-1:0] int_enable;

   // Fine clock pin passes three flops (two sync, one edge pulse) before counting
   hcc_sync u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in(fine_clock),
      .rise(fine_rise)
   );

   // Period match; held off while stopped so counts stay frozen
   assign match = s_q.run && (s_q.sys_cnt == s_q.period);
   // New capture while the last one was still unserviced
   assign overrun = match && int_status[`HCC_INT_MATCH_BIT];
   assign int_set = {overrun, match};
   assign wr_int_enable = wr_en && (addr == `HCC_OFS_INT_ENABLE);
   assign wr_int_clear = wr_en && (addr == `HCC_OFS_INT_CLEAR);

   hcc_irq u_irq (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .set(int_set),
      .wr_enable(wr_int_enable),
      .wr_clear(wr_int_clear),
      .wdata(wr_data[`HCC_IRQ_W-1:0]),
      .status(int_status),
      .enable(int_enable),
      .irq(irq)
   );

   // Counters, captures, control writes and read mux
   always_comb begin
      s_d = s_q;
      if (s_q.run) begin
         s_d.sys_cnt = s_q.sys_cnt + `HCC_CNT_W'(1);
         if (fine_rise) begin
            s_d.fine_cnt = s_q.fine_cnt + `HCC_CNT_W'(1);
         end
      end
      // Captures only change here, so software sees a consistent pair
      if (match) begin
         s_d.sys_cap = s_q.sys_cnt;
         s_d.fine_cap = s_q.fine_cnt;
         s_d.sys_cnt = '0;
         s_d.fine_cnt = '0;
      end
      if (wr_en) begin
         case (addr)
            `HCC_OFS_CTRL: begin
               s_d.run = wr_data[`HCC_CTRL_RUN_BIT];
            end
            `HCC_OFS_PERIOD: begin
               s_d.period = wr_data;
            end
            default: begin
            end
         endcase
      end
      // Read data valid only in the cycle after the strobe
      s_d.rd_data = '0;
      if (rd_en) begin
         case (addr)
            `HCC_OFS_CTRL: s_d.rd_data = {{(`HCC_DATA_W-1){1'b0}}, s_q.run};
            `HCC_OFS_PERIOD: s_d.rd_data = s_q.period;
            `HCC_OFS_SYS_CAP: s_d.rd_data = s_q.sys_cap;
            `HCC_OFS_FINE_CAP: s_d.rd_data = s_q.fine_cap;
            `HCC_OFS_SYS_CNT: s_d.rd_data = s_q.sys_cnt;
            `HCC_OFS_FINE_CNT: s_d.rd_data = s_q.fine_cnt;
            `HCC_OFS_INT_STATUS: begin
               s_d.rd_data = {{(`HCC_DATA_W-`HCC_IRQ_W){1'b0}}, int_status};
            end
            `HCC_OFS_INT_ENABLE: begin
               s_d.rd_data = {{(`HCC_DATA_W-`HCC_IRQ_W){1'b0}}, int_enable};
            end
            default: s_d.rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.run <= `HCC_RST_RUN;
         s_q.period <= `HCC_RST_PERIOD;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd_data;

endmodule

`default_nettype wire

// File: hcc_defines.svh
// Constants for the fine capture calibration block: offsets, fields, resets.
// Assumes inclusion by bare name from every design file that needs them.
//
// Function
// - Two counters gated by run, one on fine clock edges, one on system clock.
// - System clock counter is compared with the calibration period every cycle while run is set.
// - On a match both counts are latched, then both counters restart at zero.
// - Every period match sets the match status bit; irq rises only while a set status bit (match or overrun) has its enable set (reset value 0).
`ifndef HCC_DEFINES_SVH
`define HCC_DEFINES_SVH

`define HCC_ADDR_W 8
`define HCC_DATA_W 32
`define HCC_CNT_W 32
`define HCC_IRQ_W 2

// Register byte offsets
`define HCC_OFS_CTRL 8'h00
`define HCC_OFS_PERIOD 8'h04
`define HCC_OFS_SYS_CAP 8'h08
`define HCC_OFS_FINE_CAP 8'h0c
`define HCC_OFS_SYS_CNT 8'h10
`define HCC_OFS_FINE_CNT 8'h14
`define HCC_OFS_INT_STATUS 8'h18
`define HCC_OFS_INT_CLEAR 8'h1c
`define HCC_OFS_INT_ENABLE 8'h20

// Field positions
`define HCC_CTRL_RUN_BIT 0
`define HCC_INT_MATCH_BIT 0
`define HCC_INT_OVERRUN_BIT 1

// Reset values
`define HCC_RST_RUN 1'b1
`define HCC_RST_PERIOD 32'h0000ffff
`define HCC_RST_INT_ENABLE 2'h0

// Scale conversion divisor used by software
`define HCC_SCALE_DIV 128

`endif

// File: hcc_pkg.sv
// Types for the fine capture calibration block.
// Assumes hcc_defines.svh is on the include path.
`default_nettype none
`include "hcc_defines.svh"

package hcc_pkg;

   // Whole state of the top module
   typedef struct packed {
      logic run;
      logic [`HCC_CNT_W-1:0] period;
      logic [`HCC_CNT_W-1:0] sys_cnt;
      logic [`HCC_CNT_W-1:0] fine_cnt;
      logic [`HCC_CNT_W-1:0] sys_cap;
      logic [`HCC_CNT_W-1:0] fine_cap;
      logic [`HCC_DATA_W-1:0] rd_data;
   } hcc_core_t;

   // Synchroniser and edge detector state
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic rise;
   } hcc_sync_t;

   // Interrupt state
   typedef struct packed {
      logic [`HCC_IRQ_W-1:0] status;
      logic [`HCC_IRQ_W-1:0] enable;
      logic irq;
   } hcc_irq_state_t;

endpackage

`default_nettype wire

// File: hcc_sync.sv
// Two-flop synchroniser with a rising edge pulse for the fine clock pin.
// Assumes the pin toggles slower than half of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module hcc_sync
   import hcc_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic pin_in, // Asynchronous pin
   output logic rise // One-cycle pulse per rising edge
);

   hcc_sync_t s_q;
   hcc_sync_t s_d;

   // Edge detect looks only at the second flop and later
   always_comb begin
      s_d = s_q;
      s_d.meta = pin_in;
      s_d.sync = s_q.meta;
      s_d.last = s_q.sync;
      s_d.rise = s_q.sync & ~s_q.last;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise = s_q.rise;

endmodule

`default_nettype wire

// File: hcc_irq.sv
// Sticky interrupt status with enable and write-one-to-clear.
// Assumes set pulses and writes come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_defines.svh"

module hcc_irq
   import hcc_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [`HCC_IRQ_W-1:0] set, // Event pulses
   input wire logic wr_enable, // Enable register write
   input wire logic wr_clear, // Clear register write
   input wire logic [`HCC_IRQ_W-1:0] wdata, // Write data
   output logic [`HCC_IRQ_W-1:0] status, // Sticky status
   output logic [`HCC_IRQ_W-1:0] enable, // Enable mask
   output logic irq // Level interrupt
);

   hcc_irq_state_t s_q;
   hcc_irq_state_t s_d;

   // Set beats clear so an event in the clearing cycle survives
   always_comb begin
      s_d = s_q;
      if (wr_clear) begin
         s_d.status = s_q.status & ~wdata;
      end
      s_d.status = s_d.status | set;
      if (wr_enable) begin
         s_d.enable = wdata;
      end
      s_d.irq = |(s_d.status & s_d.enable);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_q.status <= '0;
         s_q.enable <= `HCC_RST_INT_ENABLE;
         s_q.irq <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.status;
   assign enable = s_q.enable;
   assign irq = s_q.irq;

endmodule

`default_nettype wire

// File: hcc_assertions.sv
// Port checker for hcc_top, bound below.
// Assumes one ref_clk domain and a period set once after reset.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_defines.svh"
module hcc_chk (
   input wire logic ref_clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic [`HCC_ADDR_W-1:0] addr, // Address
   input wire logic [`HCC_DATA_W-1:0] wr_data, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   input wire logic [`HCC_DATA_W-1:0] rd_data, // Read data
   input wire logic irq // Interrupt
);
   logic [31:0] per_q;
   logic [1:0] en_q;
   logic rc;
   logic rs;
   // Read strobes of the counter and the capture
   assign rc = rd_en && addr == `HCC_OFS_SYS_CNT;
   assign rs = rd_en && addr == `HCC_OFS_SYS_CAP;
   // Shadows of period and enable, so limits track software
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         per_q <= `HCC_RST_PERIOD;
         en_q <= 2'h0;
      end else if (wr_en && addr == `HCC_OFS_PERIOD) begin
         per_q <= wr_data;
      end else if (wr_en && addr == `HCC_OFS_INT_ENABLE) begin
         en_q <= wr_data[1:0];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   cnt_step_a: assert property (rc ##1 rc |=>
      rd_data inside {$past(rd_data), $past(rd_data) + 1, 32'h0})
      else $error("counter step wrong");
   cnt_bound_a: assert property (rc |=> rd_data <= per_q)
      else $error("counter passed period");
   cap_value_a: assert property (rs |=> rd_data == 0 || rd_data == per_q)
      else $error("capture not period");
   cap_hold_a: assert property (rs ##1 rs |=> $past(rd_data) == 0 || $stable(rd_data))
      else $error("capture moved");
   irq_mask_a: assert property ((en_q == 2'h0) [*2] |-> !irq)
      else $error("masked irq high");
   rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 0)
      else $error("stray read data");
   cover property (rs ##1 rs);
   cover property ($rose(irq));
   cover property (rc ##1 rc);
endmodule
bind hcc_top hcc_chk hcc_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr),
   .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));
`default_nettype wire

// File: hcc_bench.sv
// Self-checking bench for hcc_top.
// Assumes the checker binds itself; fine clock made here.
`timescale 1ns/1ps
`default_nettype none
`include "hcc_defines.svh"
module hcc_bench;
   logic ref_clk = 0, sys_rst = 1, fine_clock = 0, wr_en = 0, rd_en = 0, irq;
   logic [`HCC_ADDR_W-1:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h0, rd_data, v1, v2, p;
   logic [1:0] fc = 2'h0;
   integer n_fail = 0, checks = 0, seed = 74267, k, i;
   integer cs, scale, ns_val;
   hcc_top hcc_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .fine_clock(fine_clock),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .irq(irq));
   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;
   // Fine clock of 8 cycles, slow enough for the synchroniser
   always @(posedge ref_clk) begin
      fc <= fc + 2'h1;
      if (fc == 2'h3) fine_clock <= ~fine_clock;
   end
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   // Two reads back to back, results in v1 and v2
   task rd(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      #1 v1 = rd_data;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 v2 = rd_data;
   endtask
   task end_of_test;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_fail++;
      end_of_test;
   end
   // Model keeps the period; fine count is (period + 1) over 8, edges miss the match edge
   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      k = 3 + {$random(seed)} % 4;
      p = 8 * k - 1;
      wr(`HCC_OFS_PERIOD, p);
      wr(`HCC_OFS_INT_ENABLE, 32'h1);
      rd(`HCC_OFS_CTRL);
      cmp(v1, 32'h1);
      rd(`HCC_OFS_PERIOD);
      cmp(v1, p);
      rd(`HCC_OFS_INT_ENABLE);
      cmp(v1, 32'h1);
      for (i = 0; i < 300 && irq !== 1'b1; i++) @(negedge ref_clk);
      cmp(irq, 32'h1);
      rd(`HCC_OFS_INT_STATUS);
      cmp(v1, 32'h1);
      // Handler work right after the interrupt, on the pair just latched
      rd(`HCC_OFS_SYS_CAP);
      cmp(v1, p);
      cmp(v2, v1);
      cs = v1;
      rd(`HCC_OFS_FINE_CAP);
      cmp(v1, k);
      scale = cs / v1;
      cmp(scale, p / k);
      ns_val = v1 * scale / (`HCC_SCALE_DIV * 25);
      cmp(ns_val, (k * (p / k)) / (`HCC_SCALE_DIV * 25));
      rd(`HCC_OFS_SYS_CNT);
      cmp(v2, v1 == p ? 32'h0 : v1 + 1);
      repeat (p + 2) @(posedge ref_clk);
      rd(`HCC_OFS_INT_STATUS);
      cmp(v1, 32'h3);
      rd(`HCC_OFS_FINE_CAP);
      cmp(v1, k);
      wr(`HCC_OFS_CTRL, 32'h0);
      rd(`HCC_OFS_SYS_CNT);
      cmp(v2, v1);
      rd(`HCC_OFS_FINE_CNT);
      cmp(v2, v1);
      wr(`HCC_OFS_INT_CLEAR, 32'h3);
      rd(`HCC_OFS_INT_STATUS);
      cmp(v1, 32'h0);
      cmp(irq, 32'h0);
      wr(`HCC_OFS_INT_ENABLE, 32'h0);
      wr(`HCC_OFS_CTRL, 32'h1);
      repeat (p + 2) @(posedge ref_clk);
      rd(`HCC_OFS_INT_STATUS);
      cmp(v1[0], 32'h1);
      cmp(irq, 32'h0);
      rd(8'h40);
      cmp(v1, 32'h0);
      end_of_test;
   end
endmodule
`default_nettype wire
